// File: design/comparator_control_flags.sv
/*
  Control register, output state and sticky edge flags of one comparator,
  together with the rise and fall interrupt gates that qualify the flags.
  Assumes a synchronous special-function register port on i_clock that
  raises one strobe for one cycle per access, an analog core whose raw
  output is asynchronous to the clock, and an interrupt controller that
  treats both requests as levels.
*/
`timescale 1ns/10ps
`default_nettype none

// Operation
// - on bit enables or disables comparator
// - output state readable, read-only bit
// - detect rising and falling output transitions
// - falling transition sets fall flag
// - rising transition sets rise flag
// - flags sticky until software writes zero
// - hysteresis in low four bits
// - negative select: off, 5, 10, 20 mV
// - positive select encoded like negative
// - control register resets to zero
// - disabled comparator drives pin output low
// - separate gates for rise, fall interrupts
module comparator_control_flags
  import comparator_control_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // register port
  input wire sfr_request_type i_sfr,
  output logic [7:0] o_read_data,
  // analog core
  input wire logic i_comparator_raw,
  output analog_settings_type o_analog,
  // pin and interrupt side
  output logic o_pin_output,
  output logic o_rise_request,
  output logic o_fall_request
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // control register fields
  logic comparator0_on_bit;
  logic comparator0_rise_event_flag;
  logic comparator0_fall_event_flag;
  hysteresis_type comparator0_positive_hysteresis_select;
  hysteresis_type comparator0_negative_hysteresis_select;
  // interrupt gates
  logic rise_interrupt_gate;
  logic fall_interrupt_gate;
  // synchronised output and its one-cycle history
  logic output_state;
  logic output_prev;
  // registered read data
  logic [7:0] read_data;

  // next values of the control register
  logic next_on;
  logic next_rise_flag;
  logic next_fall_flag;
  hysteresis_type next_pos_hyst;
  hysteresis_type next_neg_hyst;
  // next values of the gates, history and read data
  logic next_rise_gate;
  logic next_fall_gate;
  logic next_output_prev;
  logic [7:0] next_read_data;

  // decoded strobes and detected edges
  logic control_write;
  logic gate_write;
  logic rise_edge;
  logic fall_edge;

  // ------------------------------------------------------------
  // synchroniser and edge detection
  // ------------------------------------------------------------
  output_sync sync_inst (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_async(i_comparator_raw),
    .o_sync(output_state)
  );

  // edges only counted while enabled, so a disabled core adds no events
  assign rise_edge = comparator0_on_bit && output_state && !output_prev;
  assign fall_edge = comparator0_on_bit && !output_state && output_prev;

  assign control_write = i_sfr.write && (i_sfr.address == COMPARATOR0_CONTROL_ADDR);
  assign gate_write = i_sfr.write && (i_sfr.address == RISE_FALL_GATE_ADDR);

  // ------------------------------------------------------------
  // next-state of registers and flags
  // ------------------------------------------------------------
  always_comb begin
    next_on = comparator0_on_bit;
    next_pos_hyst = comparator0_positive_hysteresis_select;
    next_neg_hyst = comparator0_negative_hysteresis_select;
    next_rise_flag = comparator0_rise_event_flag;
    next_fall_flag = comparator0_fall_event_flag;
    if (control_write) begin
      next_on = i_sfr.data[ON_BIT];
      next_pos_hyst = hysteresis_type'(i_sfr.data[POS_HYST_LSB +: 2]);
      next_neg_hyst = hysteresis_type'(i_sfr.data[NEG_HYST_LSB +: 2]);
      // software may write flags either way; a 1 write also sets them
      next_rise_flag = i_sfr.data[RISE_FLAG_BIT];
      next_fall_flag = i_sfr.data[FALL_FLAG_BIT];
    end
    // a hardware event wins over a clear in the same cycle
    if (rise_edge) begin
      next_rise_flag = 1'b1;
    end
    if (fall_edge) begin
      next_fall_flag = 1'b1;
    end
  end

  // gates change only on their own register write
  always_comb begin
    next_rise_gate = rise_interrupt_gate;
    next_fall_gate = fall_interrupt_gate;
    if (gate_write) begin
      next_rise_gate = i_sfr.data[RISE_GATE_BIT];
      next_fall_gate = i_sfr.data[FALL_GATE_BIT];
    end
  end

  // history follows the synchronised level every cycle, even while off,
  // so that enabling never compares against a stale level
  always_comb begin
    next_output_prev = output_state;
  end

  // ------------------------------------------------------------
  // read data mux, registered
  // ------------------------------------------------------------
  always_comb begin
    next_read_data = read_data;
    if (i_sfr.read) begin
      next_read_data = 8'h00;
      if (i_sfr.address == COMPARATOR0_CONTROL_ADDR) begin
        next_read_data[ON_BIT] = comparator0_on_bit;
        next_read_data[OUTPUT_STATE_BIT] = output_state;
        next_read_data[RISE_FLAG_BIT] = comparator0_rise_event_flag;
        next_read_data[FALL_FLAG_BIT] = comparator0_fall_event_flag;
        next_read_data[POS_HYST_LSB +: 2] = comparator0_positive_hysteresis_select;
        next_read_data[NEG_HYST_LSB +: 2] = comparator0_negative_hysteresis_select;
      end else if (i_sfr.address == RISE_FALL_GATE_ADDR) begin
        next_read_data[RISE_GATE_BIT] = rise_interrupt_gate;
        next_read_data[FALL_GATE_BIT] = fall_interrupt_gate;
      end
    end
  end

  // control register; reset gives the all-zero value
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      comparator0_on_bit <= CONTROL_RESET[ON_BIT];
      comparator0_rise_event_flag <= CONTROL_RESET[RISE_FLAG_BIT];
      comparator0_fall_event_flag <= CONTROL_RESET[FALL_FLAG_BIT];
      comparator0_positive_hysteresis_select <= hyst_off;
      comparator0_negative_hysteresis_select <= hyst_off;
    end else begin
      comparator0_on_bit <= next_on;
      comparator0_rise_event_flag <= next_rise_flag;
      comparator0_fall_event_flag <= next_fall_flag;
      comparator0_positive_hysteresis_select <= next_pos_hyst;
      comparator0_negative_hysteresis_select <= next_neg_hyst;
    end
  end

  // interrupt gates, closed after reset so no request leaks out early
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rise_interrupt_gate <= GATE_RESET[RISE_GATE_BIT];
      fall_interrupt_gate <= GATE_RESET[FALL_GATE_BIT];
    end else begin
      rise_interrupt_gate <= next_rise_gate;
      fall_interrupt_gate <= next_fall_gate;
    end
  end

  // edge history; reset matches the low idle level of the synchroniser
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      output_prev <= 1'b0;
    end else begin
      output_prev <= next_output_prev;
    end
  end

  // read data, held between reads
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      read_data <= 8'h00;
    end else begin
      read_data <= next_read_data;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // read data come from a flop and stand for the whole next cycle
  assign o_read_data = read_data;
  // settings come straight from flops, so the core never sees a glitch
  assign o_analog.enable = comparator0_on_bit;
  assign o_analog.positive_hysteresis_select = comparator0_positive_hysteresis_select;
  assign o_analog.negative_hysteresis_select = comparator0_negative_hysteresis_select;
  // pin held low while off so a floating core cannot toggle it
  assign o_pin_output = comparator0_on_bit && output_state;
  // requests are levels from the sticky flags, cleared by software
  assign o_rise_request = rise_interrupt_gate && comparator0_rise_event_flag;
  assign o_fall_request = fall_interrupt_gate && comparator0_fall_event_flag;

endmodule

`default_nettype wire

// File: design/comparator_control_pkg.sv
/*
  Constants and carrier types for the comparator control block.
  Assumes the special-function register port decodes an 8-bit address space.
*/
package comparator_control_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] COMPARATOR0_CONTROL_ADDR = 8'h9B;
  localparam logic [7:0] RISE_FALL_GATE_ADDR = 8'h9D;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] GATE_RESET = 8'h00;

  // ------------------------------------------------------------
  // control and gate register field positions
  // ------------------------------------------------------------
  localparam int ON_BIT = 7;
  localparam int OUTPUT_STATE_BIT = 6;
  localparam int RISE_FLAG_BIT = 5;
  localparam int FALL_FLAG_BIT = 4;
  localparam int POS_HYST_LSB = 2;
  localparam int NEG_HYST_LSB = 0;
  localparam int RISE_GATE_BIT = 5;
  localparam int FALL_GATE_BIT = 4;

  // ------------------------------------------------------------
  // hysteresis encodings, same for both directions
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    hyst_off = 2'b00,
    hyst_5mv = 2'b01,
    hyst_10mv = 2'b10,
    hyst_20mv = 2'b11
  } hysteresis_type;

  // settings sent to the analog core
  typedef struct packed {
    logic enable;
    hysteresis_type positive_hysteresis_select;
    hysteresis_type negative_hysteresis_select;
  } analog_settings_type;

  // register port request
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] address;
    logic [7:0] data;
  } sfr_request_type;

endpackage

// File: design/output_sync.sv
/*
  Two-stage synchroniser for the asynchronous comparator output.
  Assumes the input is free of any clock relation to i_clock.
*/
`timescale 1ns/10ps
`default_nettype none

module output_sync (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // asynchronous level
  input wire logic i_async,
  // synchronised level
  output logic o_sync
);

  logic meta;
  logic next_meta;
  logic next_sync;

  // first stage feeds only the second
  always_comb begin
    next_meta = i_async;
    next_sync = meta;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta <= next_meta;
      o_sync <= next_sync;
    end
  end

endmodule

`default_nettype wire

// File: bench/comparator_control_flags_asserts.sv
/*
  Port checker for the comparator control block.
  Assumes one clock domain; bound from the bench top file.
*/
`timescale 1ns/10ps
`default_nettype none
module comparator_control_flags_asserts
  import comparator_control_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // observed ports
  input wire sfr_request_type i_sfr,
  input wire logic [7:0] o_read_data,
  input wire logic i_comparator_raw,
  input wire analog_settings_type o_analog,
  input wire logic o_pin_output,
  input wire logic o_rise_request,
  input wire logic o_fall_request
);
  // ------
  // helpers
  // ------
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  wire logic wr_ctl = i_sfr.write && i_sfr.address == COMPARATOR0_CONTROL_ADDR;
  wire logic rd_ctl = i_sfr.read && i_sfr.address == COMPARATOR0_CONTROL_ADDR;
  wire logic wr_gate = i_sfr.write && i_sfr.address == RISE_FALL_GATE_ADDR;
  wire logic won = i_sfr.data[7];
  wire logic [3:0] whyst = i_sfr.data[3:0];
  logic [1:0] gate;
  // gate copy, since the checker cannot see inside
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gate <= 2'b00;
    end else if (wr_gate) begin
      gate <= i_sfr.data[5:4];
    end
  end
  // raw held for three samples while on
  sequence raw_quiet;
    (o_analog.enable && $stable(i_comparator_raw)) [*3];
  endsequence
  // while on, the pin equals the synchronised state that a read returns
  property read_shows;
    rd_ctl && o_analog.enable
      |=> o_read_data[7:6] == {$past(o_analog.enable), $past(o_pin_output)}
        && o_read_data[3:0] == $past(o_analog[3:0]);
  endproperty
  // ------
  // assertions
  // ------
  enable_write_a: assert property (
    wr_ctl |=> o_analog.enable == $past(won)) else $error("enable not written");
  hyst_write_a: assert property (
    wr_ctl |=> o_analog[3:0] == $past(whyst)) else $error("hysteresis not written");
  settings_hold_a: assert property (
    !wr_ctl |=> $stable(o_analog)) else $error("settings moved without write");
  pin_low_a: assert property (
    !o_analog.enable && !$past(o_analog.enable) |-> !o_pin_output) else $error("pin high off");
  pin_follow_a: assert property (
    raw_quiet |-> o_pin_output == i_comparator_raw) else $error("pin not following");
  rise_req_a: assert property (
    $rose(o_pin_output) && $past(o_analog.enable) && gate[1] && !wr_gate
      |-> ##[0:1] o_rise_request) else $error("rise request missing");
  fall_req_a: assert property (
    $fell(o_pin_output) && o_analog.enable && $past(o_analog.enable, 2) && gate[0]
      && !wr_gate |-> ##[0:1] o_fall_request) else $error("fall request missing");
  flags_sticky_a: assert property (
    !i_sfr.write |=> !$fell(o_rise_request) && !$fell(o_fall_request))
    else $error("request dropped by itself");
  read_ctl_a: assert property (read_shows)
    else $error("control read wrong");
endmodule
`default_nettype wire

// File: bench/comparator_core_model.sv
/*
  Stand-in for the analog comparator core.
  Assumes the bench sets which input is higher.
*/
`timescale 1ns/10ps
`default_nettype none
module comparator_core_model
  import comparator_control_pkg::*;
(
  // settings and stimulus
  input wire analog_settings_type i_analog,
  input wire logic i_above,
  // raw output
  output logic o_raw
);
  // powered-down core has no valid decision, so it reads low
  assign o_raw = i_analog.enable & i_above;
endmodule
`default_nettype wire

// File: bench/comparator_control_flags_bench.sv
/*
  Self-checking bench for the comparator control block.
  Assumes the core model and checker files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module comparator_control_flags_bench;
  import comparator_control_pkg::*;
  localparam logic [7:0] C = COMPARATOR0_CONTROL_ADDR;
  localparam logic [7:0] G = RISE_FALL_GATE_ADDR;
  logic i_clock = 0;
  logic i_arst_n = 0;
  sfr_request_type i_sfr = '0;
  logic above = 0;
  logic i_comparator_raw;
  logic [7:0] o_read_data;
  analog_settings_type o_analog;
  logic o_pin_output;
  logic o_rise_request;
  logic o_fall_request;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #4 i_clock = ~i_clock;
  comparator_control_flags dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_sfr(i_sfr),
    .o_read_data(o_read_data), .i_comparator_raw(i_comparator_raw), .o_analog(o_analog),
    .o_pin_output(o_pin_output), .o_rise_request(o_rise_request),
    .o_fall_request(o_fall_request));
  comparator_core_model core (.i_analog(o_analog), .i_above(above), .o_raw(i_comparator_raw));
  // one strobe cycle, released at the edge that takes it
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_sfr <= '{write: w, read: !w, address: a, data: d};
    @(posedge i_clock);
    i_sfr <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    access(1'b0, a, 8'h00);
    @(posedge i_clock);
    #1 `CHK("read_data", e, o_read_data)
  endtask
  // five cycles covers the two-flop sync plus flag
  task automatic level(input logic v);
    @(posedge i_clock);
    above <= v;
    repeat (5) @(posedge i_clock);
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard, far above the roughly 80 cycles needed
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge i_clock);
    i_arst_n <= 1;
    rd(C, CONTROL_RESET);
    rd(G, GATE_RESET);
    for (int i = 0; i < 4; i++) begin
      access(1'b1, C, {4'h8, i[1:0], ~i[1:0]});
      #1 `CHK("analog", {1'b1, i[1:0], ~i[1:0]}, o_analog)
    end
    access(1'b1, C, 8'h80);
    access(1'b1, G, 8'h30);
    rd(G, 8'h30);
    level(1'b1);
    rd(C, 8'hE0);
    `CHK("pin", 1'b1, o_pin_output)
    `CHK("requests", 2'b10, {o_rise_request, o_fall_request})
    level(1'b0);
    rd(C, 8'hB0);
    `CHK("requests", 2'b11, {o_rise_request, o_fall_request})
    access(1'b1, C, 8'hA0);
    access(1'b1, G, 8'h10);
    rd(C, 8'hA0);
    `CHK("requests", 2'b00, {o_rise_request, o_fall_request})
    access(1'b1, C, 8'h40);
    level(1'b1);
    rd(C, 8'h00);
    `CHK("pin", 1'b0, o_pin_output)
    rd(8'h9C, 8'h00);
    access(1'b1, C, 8'h8F);
    @(posedge i_clock);
    i_arst_n <= 0;
    repeat (2) @(posedge i_clock);
    i_arst_n <= 1;
    rd(C, CONTROL_RESET);
    end_of_test();
  end
endmodule
bind comparator_control_flags comparator_control_flags_asserts chk (.i_clock(i_clock),
  .i_arst_n(i_arst_n), .i_sfr(i_sfr), .o_read_data(o_read_data),
  .i_comparator_raw(i_comparator_raw), .o_analog(o_analog), .o_pin_output(o_pin_output),
  .o_rise_request(o_rise_request), .o_fall_request(o_fall_request));
`default_nettype wire
